/* File: rtl/tio_pkg.sv */
// Package of constants for the trigger line router
package tio_pkg;
   localparam int TIO_LINES = 4;
   localparam int TIO_CHANNELS = 3;
   localparam int TIO_MEAS_W = 16;
   // Register offsets
   localparam logic [3:0] TIO_REG_CFG0 = 4'h0;
   localparam logic [3:0] TIO_REG_CFG1 = 4'h1;
   localparam logic [3:0] TIO_REG_CFG2 = 4'h2;
   localparam logic [3:0] TIO_REG_CFG3 = 4'h3;
   localparam logic [3:0] TIO_REG_VTH = 4'h4;
   localparam logic [3:0] TIO_REG_ITH = 4'h5;
   localparam logic [3:0] TIO_REG_STATUS = 4'h6;
   localparam logic [3:0] TIO_REG_CHREQ = 4'h7;
   // Line configuration field positions
   localparam int TIO_F_EN = 0;
   localparam int TIO_F_DIR = 1;
   localparam int TIO_F_POL = 2;
   localparam int TIO_F_CH_LO = 3;
   localparam int TIO_F_MODE_LO = 5;
   localparam int TIO_F_EVT_LO = 9;
   localparam logic [31:0] TIO_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] TIO_UNMAPPED = 32'h0000_0000;
   // Status field positions
   localparam int TIO_S_OUT_LO = 0;
   localparam int TIO_S_INH_LO = 4;
   localparam int TIO_S_SEQ = 8;
   localparam int TIO_S_LINE_LO = 12;
   // Channel request fields: bits 2:0 on, bits 6:4 off
   localparam int TIO_Q_ON_LO = 0;
   localparam int TIO_Q_OFF_LO = 4;
   // Input responses
   localparam logic [3:0] TIO_IN_ON = 4'h0;
   localparam logic [3:0] TIO_IN_OFF = 4'h1;
   localparam logic [3:0] TIO_IN_TOGGLE = 4'h2;
   localparam logic [3:0] TIO_IN_INHIBIT = 4'h3;
   localparam logic [3:0] TIO_IN_SEQ_LVL = 4'h4;
   localparam logic [3:0] TIO_IN_SEQ_PLS = 4'h5;
   // Output conditions
   localparam logic [3:0] TIO_OC_ON = 4'h0;
   localparam logic [3:0] TIO_OC_OFF = 4'h1;
   localparam logic [3:0] TIO_OC_FUSE = 4'h2;
   localparam logic [3:0] TIO_OC_CC = 4'h3;
   localparam logic [3:0] TIO_OC_VTH = 4'h4;
   localparam logic [3:0] TIO_OC_ITH = 4'h5;
   localparam logic [3:0] TIO_OC_CRIT = 4'h6;
   localparam logic [3:0] TIO_OC_SEQ = 4'h7;
   // Critical event selection
   localparam logic [1:0] TIO_EV_OV = 2'h0;
   localparam logic [1:0] TIO_EV_OP = 2'h1;
   localparam logic [1:0] TIO_EV_OT = 2'h2;
endpackage

/* File: rtl/tio_trigger_io_router.sv */
// Four-line trigger router between trigger pins and channel control
//
// Chosen here: the address map and strobed register access.
module tio_trigger_io_router
   import tio_pkg::*;
#(
   parameter int LINES = TIO_LINES,
   parameter int CHANNELS = TIO_CHANNELS,
   parameter int MEAS_W = TIO_MEAS_W
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Trigger pins
   input wire logic [LINES-1:0] trigger_line_i,
   output logic [LINES-1:0] trigger_line_o,
   output logic [LINES-1:0] trigger_line_oe_o,
   // Channel status from channel control
   input wire logic [CHANNELS-1:0] ch_fuse_trip_i,
   input wire logic [CHANNELS-1:0] constant_current_regulation_i,
   input wire logic [CHANNELS-1:0] over_voltage_event_i,
   input wire logic [CHANNELS-1:0] over_power_event_i,
   input wire logic [CHANNELS-1:0] over_temp_event_i,
   input wire logic [CHANNELS*MEAS_W-1:0] ch_voltage_i,
   input wire logic [CHANNELS*MEAS_W-1:0] ch_current_i,
   input wire logic waveform_sequencer_running_i,
   // Manual and remote output requests, one-cycle pulses
   input wire logic [CHANNELS-1:0] user_on_req_i,
   input wire logic [CHANNELS-1:0] user_off_req_i,
   // Channel control outputs
   output logic [CHANNELS-1:0] ch_output_on_o,
   output logic [CHANNELS-1:0] ch_inhibit_o,
   output logic waveform_sequencer_run_o,
   output logic waveform_sequencer_start_o
);

   initial begin
      if (LINES != TIO_LINES)
         $error("tio_trigger_io_router: the register map serves four lines only");
      if (CHANNELS != TIO_CHANNELS)
         $error("tio_trigger_io_router: the channel field selects three channels only");
      if (MEAS_W < 1 || MEAS_W > 32)
         $error("tio_trigger_io_router: measurement width must be 1 to 32 bits");
   end

   // Channel index 0..2 from the two-bit field; code 3 selects nothing
   function automatic logic [CHANNELS-1:0] ch_onehot(input logic [1:0] sel);
      logic [CHANNELS-1:0] v;
      v = '0;
      if (sel < 2'd3)
         v[sel] = 1'b1;
      return v;
   endfunction

   // Field decoders shared by the input, output and pin logic
   function automatic logic cfg_in(input logic [31:0] cfg);
      return cfg[TIO_F_EN] && !cfg[TIO_F_DIR];
   endfunction

   function automatic logic cfg_out(input logic [31:0] cfg);
      return cfg[TIO_F_EN] && cfg[TIO_F_DIR];
   endfunction

   function automatic logic [1:0] cfg_ch(input logic [31:0] cfg);
      return cfg[TIO_F_CH_LO +: 2];
   endfunction

   function automatic logic [3:0] cfg_mode(input logic [31:0] cfg);
      return cfg[TIO_F_MODE_LO +: 4];
   endfunction

   // One channel's measurement out of the packed bus; no channel gives zero
   function automatic logic [MEAS_W-1:0] meas_pick(input logic [CHANNELS*MEAS_W-1:0] bus,
      input logic [CHANNELS-1:0] sel);
      logic [MEAS_W-1:0] m;
      m = '0;
      for (int c = 0; c < CHANNELS; c++)
         if (sel[c])
            m = bus[c*MEAS_W +: MEAS_W];
      return m;
   endfunction

   // Status word: output states, inhibits, sequencer run, synchronised pins
   function automatic logic [31:0] status_word(input logic [CHANNELS-1:0] on,
      input logic [CHANNELS-1:0] inh, input logic run, input logic [LINES-1:0] lvl);
      logic [31:0] w;
      w = '0;
      w[TIO_S_OUT_LO +: CHANNELS] = on;
      w[TIO_S_INH_LO +: CHANNELS] = inh;
      w[TIO_S_SEQ] = run;
      w[TIO_S_LINE_LO +: LINES] = lvl;
      return w;
   endfunction

   logic [31:0] cfg_r [LINES];
   logic [MEAS_W-1:0] vth_r;
   logic [MEAS_W-1:0] ith_r;
   logic [LINES-1:0] sync1_r;
   logic [LINES-1:0] sync2_r;
   logic [LINES-1:0] act_prev_r;
   logic [CHANNELS-1:0] out_on_r;
   logic [CHANNELS-1:0] inhibit_r;
   logic seq_run_r;
   logic seq_start_r;
   logic [LINES-1:0] pin_r;
   logic [LINES-1:0] oe_r;
   logic [31:0] rdata_r;
   logic [31:0] chreq_nxt;

   logic [LINES-1:0] in_act;
   logic [LINES-1:0] in_edge;
   logic [LINES-1:0] out_cond;
   logic [CHANNELS-1:0] force_on;
   logic [CHANNELS-1:0] force_off;
   logic [CHANNELS-1:0] toggle_ev;
   logic [CHANNELS-1:0] inhibit_nxt;
   logic [CHANNELS-1:0] sw_on;
   logic [CHANNELS-1:0] sw_off;
   logic seq_lvl;
   logic seq_pls;

   // Line configuration words
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < LINES; i++)
            cfg_r[i] <= TIO_CFG_RESET;
      end else if (reg_wr_i) begin
         for (int i = 0; i < LINES; i++)
            if (reg_addr_i == TIO_REG_CFG0 + 4'(i))
               cfg_r[i] <= reg_wdata_i;
      end
   end

   // Thresholds; only the low MEAS_W bits of the word are kept
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         vth_r <= '0;
         ith_r <= '0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == TIO_REG_VTH)
            vth_r <= reg_wdata_i[MEAS_W-1:0];
         if (reg_addr_i == TIO_REG_ITH)
            ith_r <= reg_wdata_i[MEAS_W-1:0];
      end
   end

   // Software output requests through the register port or request pins
   always_comb begin
      chreq_nxt = '0;
      if (reg_wr_i && reg_addr_i == TIO_REG_CHREQ)
         chreq_nxt = reg_wdata_i;
      sw_on = user_on_req_i | chreq_nxt[TIO_Q_ON_LO +: CHANNELS];
      sw_off = user_off_req_i | chreq_nxt[TIO_Q_OFF_LO +: CHANNELS];
   end

   // Two-flop synchroniser, first stage read only by the second
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= trigger_line_i;
         sync2_r <= sync1_r;
      end
   end

   // Active level per input line, zero when disabled or an output
   always_comb begin
      for (int i = 0; i < LINES; i++) begin
         in_act[i] = cfg_in(cfg_r[i])
            && (sync2_r[i] ^ cfg_r[i][TIO_F_POL]);
         in_edge[i] = in_act[i] && !act_prev_r[i];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         act_prev_r <= '0;
      else
         act_prev_r <= in_act;
   end

   // Fold input lines into per-channel actions
   always_comb begin
      logic [CHANNELS-1:0] sel;
      logic [3:0] mode;
      sel = '0;
      mode = '0;
      force_on = '0;
      force_off = '0;
      toggle_ev = '0;
      inhibit_nxt = '0;
      seq_lvl = 1'b0;
      seq_pls = 1'b0;
      for (int i = 0; i < LINES; i++) begin
         sel = ch_onehot(cfg_ch(cfg_r[i]));
         mode = cfg_mode(cfg_r[i]);
         case (mode)
            TIO_IN_ON: if (in_act[i]) force_on = force_on | sel;
            TIO_IN_OFF: if (in_act[i]) force_off = force_off | sel;
            TIO_IN_TOGGLE: if (in_edge[i]) toggle_ev = toggle_ev ^ sel;
            TIO_IN_INHIBIT: if (in_act[i]) inhibit_nxt = inhibit_nxt | sel;
            TIO_IN_SEQ_LVL: if (in_act[i] && sel[0]) seq_lvl = 1'b1;
            TIO_IN_SEQ_PLS: if (in_edge[i] && sel[0]) seq_pls = 1'b1;
            default: ;
         endcase
      end
   end

   // Inhibit follows the inhibit lines directly, no clearing action needed
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         inhibit_r <= '0;
      else
         inhibit_r <= inhibit_nxt;
   end

   // Channel output state; inhibit and off beat on, any trigger action on a channel beats software requests
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_on_r <= '0;
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            if (inhibit_nxt[c])
               out_on_r[c] <= 1'b0;
            else if (force_off[c])
               out_on_r[c] <= 1'b0;
            else if (force_on[c])
               out_on_r[c] <= 1'b1;
            else if (toggle_ev[c])
               out_on_r[c] <= !out_on_r[c];
            else if (sw_off[c])
               out_on_r[c] <= 1'b0;
            else if (sw_on[c])
               out_on_r[c] <= 1'b1;
         end
      end
   end

   // Level start runs the sequencer for as long as the line stays active
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         seq_run_r <= 1'b0;
      else
         seq_run_r <= seq_lvl;
   end

   // A pulse gives a one-cycle start; the sequencer must latch it itself
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         seq_start_r <= 1'b0;
      else
         seq_start_r <= seq_pls;
   end

   // Output conditions per line
   always_comb begin
      logic [CHANNELS-1:0] sel;
      logic [MEAS_W-1:0] v;
      logic [MEAS_W-1:0] a;
      logic crit;
      logic [1:0] idx;
      sel = '0;
      v = '0;
      a = '0;
      crit = 1'b0;
      idx = '0;
      for (int i = 0; i < LINES; i++) begin
         idx = cfg_ch(cfg_r[i]);
         sel = ch_onehot(idx);
         v = meas_pick(ch_voltage_i, sel);
         a = meas_pick(ch_current_i, sel);
         case (cfg_r[i][TIO_F_EVT_LO +: 2])
            TIO_EV_OV: crit = |(over_voltage_event_i & sel);
            TIO_EV_OP: crit = |(over_power_event_i & sel);
            TIO_EV_OT: crit = |(over_temp_event_i & sel);
            default: crit = 1'b0;
         endcase
         case (cfg_mode(cfg_r[i]))
            TIO_OC_ON: out_cond[i] = |(out_on_r & sel);
            TIO_OC_OFF: out_cond[i] = |(~out_on_r & sel);
            TIO_OC_FUSE: out_cond[i] = |(ch_fuse_trip_i & sel);
            TIO_OC_CC: out_cond[i] = |(constant_current_regulation_i & sel);
            TIO_OC_VTH: out_cond[i] = (|sel) && (v >= vth_r);
            TIO_OC_ITH: out_cond[i] = (|sel) && (a >= ith_r);
            TIO_OC_CRIT: out_cond[i] = crit;
            TIO_OC_SEQ: out_cond[i] = waveform_sequencer_running_i;
            default: out_cond[i] = 1'b0;
         endcase
      end
   end

   // Pin enables; a line not enabled as output releases the pin
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         oe_r <= '0;
      end else begin
         for (int i = 0; i < LINES; i++)
            oe_r[i] <= cfg_out(cfg_r[i]);
      end
   end

   // Pin values; an idle line rests at its inactive level
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_r <= '0;
      end else begin
         for (int i = 0; i < LINES; i++)
            if (cfg_out(cfg_r[i]))
               pin_r[i] <= out_cond[i] ^ cfg_r[i][TIO_F_POL];
            else
               pin_r[i] <= cfg_r[i][TIO_F_POL];
      end
   end

   // Register reads, data valid the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            TIO_REG_CFG0: rdata_r <= cfg_r[0];
            TIO_REG_CFG1: rdata_r <= cfg_r[1];
            TIO_REG_CFG2: rdata_r <= cfg_r[2];
            TIO_REG_CFG3: rdata_r <= cfg_r[3];
            TIO_REG_VTH: rdata_r <= 32'(vth_r);
            TIO_REG_ITH: rdata_r <= 32'(ith_r);
            TIO_REG_STATUS: rdata_r <= status_word(out_on_r, inhibit_r, seq_run_r, sync2_r);
            default: rdata_r <= TIO_UNMAPPED;
         endcase
      end else begin
         rdata_r <= '0;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign trigger_line_o = pin_r;
   assign trigger_line_oe_o = oe_r;
   assign ch_output_on_o = out_on_r;
   assign ch_inhibit_o = inhibit_r;
   assign waveform_sequencer_run_o = seq_run_r;
   assign waveform_sequencer_start_o = seq_start_r;

endmodule

/* File: verification/tb.sv */
// Self-checking bench for the trigger line router
module tb;
   import tio_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, wr, rd, run_in, seq_run, seq_start;
   logic [3:0] addr, drv_en, drv_val, pins, pin_o, pin_oe;
   logic [31:0] wdata, rdata;
   logic [2:0] fuse, cc, ov, op, ot, on_req, off_req, ch_on, inh;
   logic [47:0] volt, curr;
   int num_errors = 0, total_checks = 0, cyc = 0, n;
   tio_trigger_io_router i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .trigger_line_i(pins), .trigger_line_o(pin_o), .trigger_line_oe_o(pin_oe),
      .ch_fuse_trip_i(fuse), .constant_current_regulation_i(cc), .over_voltage_event_i(ov),
      .over_power_event_i(op), .over_temp_event_i(ot), .ch_voltage_i(volt),
      .ch_current_i(curr), .waveform_sequencer_running_i(run_in), .user_on_req_i(on_req),
      .user_off_req_i(off_req), .ch_output_on_o(ch_on), .ch_inhibit_o(inh),
      .waveform_sequencer_run_o(seq_run), .waveform_sequencer_start_o(seq_start));
   tio_trig_partner i_far (.drv_en_i(drv_en), .drv_val_i(drv_val), .dut_o_i(pin_o),
      .dut_oe_i(pin_oe), .line_o(pins));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic summarize;
      $display("Errors %0d in %0d checks", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // The whole run needs under 400 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic wt(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic wr32(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd32(logic [3:0] a, logic [31:0] e, string s);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(s, rdata, e);
   endtask
   function automatic logic [31:0] cf(bit d, bit p, logic [1:0] c, logic [3:0] m,
      logic [1:0] e);
      return {21'h0, e, m, c, p, d, 1'b1};
   endfunction
   task automatic pin(int l, logic v);
      @(posedge clk);
      drv_val[l] <= v;
   endtask
   // Channel 0 sits right at the thresholds when b is high, one below otherwise
   task automatic st(logic b);
      @(posedge clk);
      {fuse, cc, ov, op, ot} <= {15{b}};
      run_in <= b;
      volt[15:0] <= b ? 16'h1234 : 16'h1233;
      curr[15:0] <= b ? 16'h1234 : 16'h1233;
   endtask
   initial begin
      {wr, rd, addr, wdata, on_req, off_req, fuse, cc, ov, op, ot, run_in} = '0;
      {volt, curr} = '0;
      drv_en = 4'hF;
      drv_val = 4'h0;
      rst_b = 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      wt(1);
      chk("oe", pin_oe, 0);
      rd32(TIO_REG_CFG0, TIO_CFG_RESET, "cfg0");
      rd32(4'h8, TIO_UNMAPPED, "unmapped");
      wr32(TIO_REG_CFG0, cf(0, 0, 0, TIO_IN_TOGGLE, 0));
      rd32(TIO_REG_CFG0, cf(0, 0, 0, TIO_IN_TOGGLE, 0), "cfg0");
      pin(0, 1);
      wt(2);
      chk("sync", ch_on, 0);
      wt(1);
      chk("toggle", ch_on, 3'b001);
      pin(0, 0);
      wt(4);
      pin(0, 1);
      wt(4);
      chk("toggle", ch_on, 0);
      pin(0, 0);
      wr32(TIO_REG_CFG0, 0);
      wr32(TIO_REG_CFG1, cf(0, 1, 1, TIO_IN_ON, 0));
      wt(4);
      chk("on", ch_on, 3'b010);
      @(posedge clk) off_req <= 3'b010;
      @(posedge clk) off_req <= 0;
      wt(3);
      chk("on", ch_on, 3'b010);
      pin(1, 1);
      wr32(TIO_REG_CFG1, cf(0, 1, 1, TIO_IN_OFF, 0));
      pin(1, 0);
      wt(4);
      chk("off", ch_on, 0);
      pin(1, 1);
      wr32(TIO_REG_CFG1, 0);
      wr32(TIO_REG_CHREQ, 32'h4);
      wr32(TIO_REG_CFG2, cf(0, 0, 2, TIO_IN_INHIBIT, 0));
      chk("req", ch_on, 3'b100);
      pin(2, 1);
      wt(4);
      chk("inh", {inh, ch_on}, 6'b100000);
      rd32(TIO_REG_STATUS, 32'h6040, "status");
      @(posedge clk) on_req <= 3'b100;
      @(posedge clk) on_req <= 0;
      wr32(TIO_REG_CHREQ, 32'h4);
      wt(3);
      chk("inh", ch_on, 0);
      pin(2, 0);
      wt(4);
      chk("inh", inh, 0);
      pin(2, 1);
      wt(4);
      chk("inh", inh, 3'b100);
      wr32(TIO_REG_CFG2, 0);
      wt(3);
      chk("inh", inh, 0);
      pin(2, 0);
      @(posedge clk) on_req <= 3'b001;
      @(posedge clk) on_req <= 0;
      wt(1);
      chk("user on", ch_on, 3'b001);
      wr32(TIO_REG_CHREQ, 32'h10);
      wt(1);
      chk("req off", ch_on, 0);
      wr32(TIO_REG_CFG3, cf(0, 0, 0, TIO_IN_SEQ_LVL, 0));
      pin(3, 1);
      wt(4);
      chk("run", seq_run, 1);
      pin(3, 0);
      wt(4);
      chk("run", seq_run, 0);
      for (int c = 0; c < 2; c++) begin
         wr32(TIO_REG_CFG3, cf(0, 0, 2'(c), TIO_IN_SEQ_PLS, 0));
         pin(3, 1);
         n = 0;
         repeat (8) begin
            @(posedge clk);
            #1;
            n += seq_start;
         end
         chk("start", n, c == 0);
         pin(3, 0);
         wt(3);
      end
      wr32(TIO_REG_CFG3, 0);
      drv_en <= 4'hD;
      wr32(TIO_REG_VTH, 32'h1234);
      wr32(TIO_REG_ITH, 32'h1234);
      for (int p = 0; p < 2; p++) for (int m = 0; m < 8; m++) for (int b = 0; b < 2; b++) begin
         st(b[0]);
         wr32(TIO_REG_CFG1, cf(1, p[0], 0, 4'(m), 2'(p)));
         wt(3);
         chk("out", {pin_oe[1], pin_o[1]}, {1'b1, p[0] ^ (m == 1 || (m > 1 && b[0]))});
      end
      st(0);
      @(posedge clk) ov <= 3'b001;
      wr32(TIO_REG_CFG1, cf(1, 0, 0, TIO_OC_CRIT, TIO_EV_OT));
      wt(3);
      chk("crit", pin_o[1], 0);
      wr32(TIO_REG_CFG1, 0);
      wt(3);
      chk("oe", pin_oe, 0);
      summarize();
   end
endmodule

/* File: verification/tio_router_properties.sv */
// Port checker for the trigger line router, bound to the top module
module tio_router_checker
   import tio_pkg::*;
#(
   parameter int LINES = TIO_LINES,
   parameter int CHANNELS = TIO_CHANNELS,
   parameter int MEAS_W = TIO_MEAS_W
) (
   // Clock, reset and register writes
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   // Trigger pins
   input wire logic [LINES-1:0] trigger_line_i,
   input wire logic [LINES-1:0] trigger_line_o,
   input wire logic [LINES-1:0] trigger_line_oe_o,
   // Channel side
   input wire logic [CHANNELS-1:0] ch_fuse_trip_i,
   input wire logic [CHANNELS-1:0] constant_current_regulation_i,
   input wire logic [CHANNELS-1:0] over_voltage_event_i,
   input wire logic [CHANNELS-1:0] over_power_event_i,
   input wire logic [CHANNELS-1:0] over_temp_event_i,
   input wire logic waveform_sequencer_running_i,
   input wire logic [CHANNELS-1:0] user_on_req_i,
   input wire logic [CHANNELS-1:0] ch_output_on_o,
   input wire logic [CHANNELS-1:0] ch_inhibit_o,
   input wire logic waveform_sequencer_run_o,
   input wire logic waveform_sequencer_start_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] cfg_r [LINES];
   logic [LINES*11-1:0] cfg_f;
   logic [LINES-1:0] oe_exp, pol_v, cv, cx;
   // Shadow of the line setup, snooped from register writes
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int l = 0; l < LINES; l++) cfg_r[l] <= '0;
      end else if (reg_wr_i && reg_addr_i < 4'(LINES)) begin
         cfg_r[reg_addr_i[1:0]] <= reg_wdata_i[10:0];
      end
   end
   // Output on/off and thresholds are left out: their timing needs more state
   function automatic logic [1:0] oc(input logic [10:0] c);
      logic [1:0] h;
      h = c[4:3];
      case (c[8:5])
         TIO_OC_FUSE: return {h != 2'h3, ch_fuse_trip_i[h]};
         TIO_OC_CC: return {h != 2'h3, constant_current_regulation_i[h]};
         TIO_OC_CRIT: return {h != 2'h3 && c[10:9] != 2'h3, c[10:9] == TIO_EV_OV ?
            over_voltage_event_i[h] : c[10:9] == TIO_EV_OP ? over_power_event_i[h] :
            over_temp_event_i[h]};
         TIO_OC_SEQ: return {h == 2'h0, waveform_sequencer_running_i};
         default: return 2'h0;
      endcase
   endfunction
   always_comb begin
      for (int l = 0; l < LINES; l++) begin
         oe_exp[l] = cfg_r[l][TIO_F_EN] & cfg_r[l][TIO_F_DIR];
         pol_v[l] = cfg_r[l][TIO_F_POL];
         {cv[l], cx[l]} = oc(cfg_r[l]);
         cx[l] = cx[l] ^ pol_v[l];
         cfg_f[l*11+:11] = cfg_r[l];
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   property p_oe_dir;
      $stable(oe_exp) |-> trigger_line_oe_o == oe_exp;
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("pin enable wrong");
   property p_idle_pol;
      $stable(cfg_f) |-> ((trigger_line_o ^ pol_v) & ~oe_exp) == '0;
   endproperty
   a_idle_pol: assert property (p_idle_pol) else $error("idle pin level wrong");
   property p_out_cond;
      $stable(cfg_f) |-> ((trigger_line_o ^ $past(cx)) & $past(cv) & oe_exp) == '0;
   endproperty
   a_out_cond: assert property (p_out_cond) else $error("pin condition wrong");
   property p_inh_off;
      (ch_inhibit_o & $past(ch_inhibit_o) & ch_output_on_o) == '0;
   endproperty
   a_inh_off: assert property (p_inh_off) else $error("inhibited channel on");
   property p_inh_user;
      (ch_inhibit_o & user_on_req_i) != '0 |=>
         (ch_output_on_o & $past(ch_inhibit_o & user_on_req_i)) == '0;
   endproperty
   a_inh_user: assert property (p_inh_user) else $error("request passed inhibit");
   property p_start_once;
      waveform_sequencer_start_o |=> !waveform_sequencer_start_o;
   endproperty
   a_start_once: assert property (p_start_once) else $error("start pulse too long");
   property p_start_cause;
      waveform_sequencer_start_o |-> $past(trigger_line_i, 3) != $past(trigger_line_i, 4);
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("start without edge");
   property p_run_cause;
      $rose(waveform_sequencer_run_o) |-> $past(trigger_line_i, 3) != $past(trigger_line_i, 4);
   endproperty
   a_run_cause: assert property (p_run_cause) else $error("run without pin change");
   c_start: cover property (waveform_sequencer_start_o);
   c_inh: cover property (ch_inhibit_o != '0);
   c_drive: cover property (trigger_line_oe_o != '0);
endmodule

bind tio_trigger_io_router tio_router_checker #(.LINES(LINES), .CHANNELS(CHANNELS),
   .MEAS_W(MEAS_W)) i_chk (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .trigger_line_i, .trigger_line_o, .trigger_line_oe_o, .ch_fuse_trip_i,
   .constant_current_regulation_i, .over_voltage_event_i, .over_power_event_i,
   .over_temp_event_i, .waveform_sequencer_running_i, .user_on_req_i, .ch_output_on_o,
   .ch_inhibit_o, .waveform_sequencer_run_o, .waveform_sequencer_start_o);

/* File: verification/tio_trig_partner.sv */
// External trigger equipment on the four lines, with pull-ups
module tio_trig_partner (
   // Equipment drive
   input wire logic [3:0] drv_en_i,
   input wire logic [3:0] drv_val_i,
   // Router pin side
   input wire logic [3:0] dut_o_i,
   input wire logic [3:0] dut_oe_i,
   output logic [3:0] line_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released line floats to the pull-up, never to its last value
   always_comb begin
      for (int l = 0; l < 4; l++) begin
         line_o[l] = dut_oe_i[l] ? dut_o_i[l] : (drv_en_i[l] ? drv_val_i[l] : 1'b1);
      end
   end
endmodule
